/* File: hdl/dtc_device.sv */
`timescale 1ns/1ps
`include "dtc_defines.svh"
// Functional notes
// RULE1: request code in top nibble, 7 writes
// RULE2: low eleven bits hold parameter number
// RULE3: second word high byte is page index
// RULE4: second word low byte is subindex
// RULE5: connector third word is source number
// RULE6: connector bits 10-15 drive object 63
// RULE7: connector bits 0-9 index or bit
// RULE8: control, setpoint in; status, actual out
// RULE9: second control word needs length four
// RULE10: on low ramps down, then drive off
// RULE11: on rising enters ready, runs if enabled
// RULE12: coast bit low cuts drive at once
// RULE13: fast stop bit low uses fast ramp
// RULE14: enable bit low cancels pulses immediately; code: only in run with on and fast stop bits high, ramp-downs keep pulses
// RULE15: generator enable low forces zero output
// RULE16: generator run low freezes output; code freezes in run only, ramp-down and fast stop keep ramping
// RULE17: setpoint enable low brakes, high accelerates
// RULE18: acknowledge rising edge clears faults
// RULE19: plc bit low ignores process data
// RULE20: reverse bit inverts setpoint
// RULE21: motorized setpoint up and down bits
// RULE22: large numbers use offset and page
// RULE23: reserved control bits ignored
module dtc_device import dtc_pkg::*; #(
  parameter logic [15:0] MOP_STEP = 16'h0001
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // telegram link
  dtc_if.dev               bus,
  // drive side
  input  wire logic        faultIn,
  output logic             pulseEnable,
  output logic      [15:0] speedOut,
  output logic      [15:0] secondCtl,
  output logic      [15:0] mopValue
);
  typedef struct packed {
    dtc_state_t  st;
    logic        rdy;
    logic        pulses;
    logic        fault;
    logic [15:0] cw;
    logic [15:0] cw2;
    logic [15:0] setpt;
    logic [15:0] motorized_setpoint;
    logic [15:0] onSrc;
    logic [9:0]  onIdx;
    logic [7:0]  onSub;
    logic [15:0] upStep;
    logic [15:0] dnStep;
    logic [15:0] fastStep;
    logic [15:0] pdLen;
    logic        rspValid;
    dtc_words_t  parRsp;
    dtc_pair_t   pdRsp;
  } dtc_dev_st_t;

  dtc_dev_st_t q, next_q;
  logic [15:0] rampVal;
  logic [15:0] target;
  logic [15:0] dnSel;
  logic        rampZero;
  logic        rampHold;
  logic [3:0]  code;
  logic [16:0] dec;
  logic [15:0] num;
  logic [15:0] rdVal;
  logic        known;
  logic        err;
  logic        onRise;
  logic        ackRise;
  logic [15:0] status;

  // ----------------------------------------
  // ramp generator
  // ----------------------------------------
  always_comb begin
    rampZero = !q.cw[`DTC_CB_RFG_EN] || !q.pulses;             // [RULE15]
    rampHold = !q.cw[`DTC_CB_RFG_RUN] && q.st == ST_RUN;       // [RULE16]
    target   = q.setpt + q.motorized_setpoint;
    if (q.cw[`DTC_CB_REV]) begin
      target = -target;                                        // [RULE20]
    end
    if (q.st != ST_RUN || !q.cw[`DTC_CB_SP_EN]) begin
      target = '0;                                             // [RULE17]
    end
    dnSel = (q.st == ST_FASTSTOP) ? q.fastStep : q.dnStep;     // [RULE13]
  end

  dtc_ramp #(.W(16)) dtc_ramp_i (
    .clk    (clk),
    .rstn   (rstn),
    .zero   (rampZero),
    .hold   (rampHold),
    .target (target),
    .upStep (q.upStep),
    .dnStep (dnSel),
    .value  (rampVal)
  );

  // ----------------------------------------
  // status word
  // ----------------------------------------
  always_comb begin
    status     = '0;
    status[0]  = q.st == ST_READY_ON;
    status[1]  = q.st == ST_READY || q.pulses;
    status[2]  = q.st == ST_RUN;
    status[3]  = q.fault;
    status[4]  = q.cw[`DTC_CB_NOCOAST];
    status[5]  = q.cw[`DTC_CB_NOFAST];
    status[6]  = q.st == ST_INHIBIT;
    status[14] = !rampVal[15] && rampVal != '0;
  end

  // ----------------------------------------
  // telegram decode and drive control
  // ----------------------------------------
  always_comb begin
    next_q          = q;
    next_q.rdy      = 1'b1;
    next_q.rspValid = 1'b0;
    code  = bus.parWord[0][15:`DTC_RC_LSB];                      // [RULE1]
    dec   = dtc_decode(bus.parWord[1][15:`DTC_PAGE_LSB],
                       bus.parWord[0][`DTC_PN_MSB:0]);   // [RULE2] [RULE3] [RULE22]
    num   = dec[15:0];
    known = dec[16];
    rdVal = '0;
    err   = 1'b0;
    if (bus.reqValid && q.rdy) begin
      if (bus.pdWord[0][`DTC_CB_PLC]) begin                      // [RULE19]
        next_q.cw    = bus.pdWord[0] & `DTC_CW_USED_MASK;  // [RULE8] [RULE23]
        next_q.setpt = bus.pdWord[1];                            // [RULE8]
        if (q.pdLen >= `DTC_PD_LEN_CW2) begin
          next_q.cw2 = bus.pdWord[2];                            // [RULE9]
        end
        if (next_q.cw[`DTC_CB_MOP_UP]) begin
          next_q.motorized_setpoint = q.motorized_setpoint + MOP_STEP;                         // [RULE21]
        end else if (next_q.cw[`DTC_CB_MOP_DN]) begin
          next_q.motorized_setpoint = q.motorized_setpoint - MOP_STEP;                         // [RULE21]
        end
      end
      case (num)
        `DTC_PN_ON_SRC:  rdVal = q.onSrc;
        `DTC_PN_RAMP_UP: rdVal = q.upStep;
        `DTC_PN_RAMP_DN: rdVal = q.dnStep;
        `DTC_PN_FAST_DN: rdVal = q.fastStep;
        `DTC_PN_PD_LEN:  rdVal = q.pdLen;
        default:         err   = 1'b1;
      endcase
      err = err || !known;
      if (code == `DTC_RC_WRITE && !err) begin                   // [RULE1]
        case (num)
          `DTC_PN_ON_SRC: begin
            err = bus.parWord[3][15:`DTC_DO_LSB] != `DTC_DO_VALUE; // [RULE6]
            if (!err) begin
              next_q.onSrc = bus.parWord[2];                     // [RULE5]
              next_q.onIdx = bus.parWord[3][`DTC_DO_LSB-1:0];    // [RULE7]
              next_q.onSub = bus.parWord[1][7:0];                // [RULE4]
            end
          end
          `DTC_PN_RAMP_UP: next_q.upStep   = bus.parWord[3];
          `DTC_PN_RAMP_DN: next_q.dnStep   = bus.parWord[3];
          `DTC_PN_FAST_DN: next_q.fastStep = bus.parWord[3];
          `DTC_PN_PD_LEN:  next_q.pdLen    = bus.parWord[3];
          default:         err = 1'b1;
        endcase
      end else if (code != `DTC_RC_READ) begin
        err = code != `DTC_RC_NONE;
      end
      next_q.rspValid  = 1'b1;
      next_q.parRsp[0] = {(code == `DTC_RC_NONE) ? `DTC_RC_NONE :
                          err ? `DTC_RC_ERR : `DTC_RC_ACK,
                          bus.parWord[0][11:0]};
      next_q.parRsp[1] = bus.parWord[1];
      next_q.parRsp[2] = (num == `DTC_PN_ON_SRC) ? q.onSrc : 16'h0000;
      next_q.parRsp[3] = (num == `DTC_PN_ON_SRC) ?
                         {`DTC_DO_VALUE, q.onIdx} : rdVal;
      next_q.pdRsp     = {rampVal, status};                      // [RULE8]
    end
    onRise  = next_q.cw[`DTC_CB_ON] && !q.cw[`DTC_CB_ON];
    ackRise = next_q.cw[`DTC_CB_ACK] && !q.cw[`DTC_CB_ACK];
    case (q.st)
      ST_FAULT: begin
        if (ackRise) begin
          next_q.fault = 1'b0;                                   // [RULE18]
          next_q.st    = ST_INHIBIT;                             // [RULE18]
        end
      end
      ST_INHIBIT: begin
        if (!next_q.cw[`DTC_CB_ON] && next_q.cw[`DTC_CB_NOCOAST] &&
            next_q.cw[`DTC_CB_NOFAST]) begin
          next_q.st = ST_READY_ON;
        end
      end
      ST_READY_ON: begin
        if (onRise) begin
          next_q.st = next_q.cw[`DTC_CB_ENOP] ? ST_RUN : ST_READY; // [RULE11]
        end
      end
      ST_READY: begin
        if (!next_q.cw[`DTC_CB_ON]) begin
          next_q.st = ST_READY_ON;
        end else if (next_q.cw[`DTC_CB_ENOP]) begin
          next_q.st = ST_RUN;                                    // [RULE14]
        end
      end
      ST_RUN: begin
        if (!next_q.cw[`DTC_CB_NOFAST]) begin
          next_q.st = ST_FASTSTOP;                               // [RULE13]
        end else if (!next_q.cw[`DTC_CB_ON]) begin
          next_q.st = ST_RAMPDN;                                 // [RULE10]
        end else if (!next_q.cw[`DTC_CB_ENOP]) begin
          next_q.st = ST_READY;                                  // [RULE14]
        end
      end
      ST_RAMPDN: begin
        if (!next_q.cw[`DTC_CB_NOFAST]) begin
          next_q.st = ST_FASTSTOP;
        end else if (onRise) begin
          next_q.st = ST_RUN;
        end else if (rampVal == '0) begin
          next_q.st = ST_READY_ON;                               // [RULE10]
        end
      end
      ST_FASTSTOP: begin
        if (rampVal == '0) begin
          next_q.st = ST_INHIBIT;                                // [RULE13]
        end
      end
      default: next_q.st = ST_INHIBIT;
    endcase
    if (!next_q.cw[`DTC_CB_NOCOAST] && next_q.st != ST_FAULT) begin
      next_q.st = ST_INHIBIT;                                    // [RULE12]
    end
    if (faultIn) begin
      next_q.fault = 1'b1;
      next_q.st    = ST_FAULT;
    end
    next_q.pulses = next_q.st == ST_RUN || next_q.st == ST_RAMPDN ||
                    next_q.st == ST_FASTSTOP;        // [RULE12] [RULE14]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q          <= '0;
      q.st       <= ST_INHIBIT;
      q.cw       <= 16'h0006;
      q.upStep   <= `DTC_RST_UP_STEP;
      q.dnStep   <= `DTC_RST_DN_STEP;
      q.fastStep <= `DTC_RST_FAST_STEP;
      q.pdLen    <= `DTC_RST_PD_LEN;
    end else begin
      q <= next_q;
    end
  end

  assign bus.reqReady = q.rdy;
  assign bus.rspValid = q.rspValid;
  assign bus.parRsp   = q.parRsp;
  assign bus.pdRsp    = q.pdRsp;
  assign pulseEnable  = q.pulses;
  assign speedOut     = rampVal;
  assign secondCtl    = q.cw2;
  assign mopValue     = q.motorized_setpoint;
endmodule : dtc_device

/* File: hdl/dtc_defines.svh */
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
// ----------------------------------------
// parameter channel fields
// ----------------------------------------
`define DTC_RC_LSB        12
`define DTC_PN_MSB        10
`define DTC_PAGE_LSB      8
`define DTC_DO_LSB        10
`define DTC_DO_VALUE      6'h3F
`define DTC_RC_NONE       4'h0
`define DTC_RC_READ       4'h6
`define DTC_RC_WRITE      4'h7
`define DTC_RC_ACK        4'h1
`define DTC_RC_ERR        4'h8
`define DTC_PN_MAXFIELD   16'h07CF
// ----------------------------------------
// device parameter numbers and resets
// ----------------------------------------
`define DTC_PN_ON_SRC     16'h0348
`define DTC_PN_RAMP_UP    16'h0460
`define DTC_PN_RAMP_DN    16'h0461
`define DTC_PN_FAST_DN    16'h046F
`define DTC_PN_PD_LEN     16'h07E6
`define DTC_RST_UP_STEP   16'h0010
`define DTC_RST_DN_STEP   16'h0010
`define DTC_RST_FAST_STEP 16'h0040
`define DTC_RST_PD_LEN    16'h0002
`define DTC_PD_LEN_CW2    16'h0004
// ----------------------------------------
// control word bits
// ----------------------------------------
`define DTC_CB_ON         0
`define DTC_CB_NOCOAST    1
`define DTC_CB_NOFAST     2
`define DTC_CB_ENOP       3
`define DTC_CB_RFG_EN     4
`define DTC_CB_RFG_RUN    5
`define DTC_CB_SP_EN      6
`define DTC_CB_ACK        7
`define DTC_CB_PLC        10
`define DTC_CB_REV        11
`define DTC_CB_MOP_UP     13
`define DTC_CB_MOP_DN     14
`define DTC_CW_USED_MASK  16'h6CFF
// ----------------------------------------
// controller register map (apb)
// ----------------------------------------
`define DTC_A_PNUM        8'h00
`define DTC_A_CODE        8'h04
`define DTC_A_VALH        8'h08
`define DTC_A_VALL        8'h0C
`define DTC_A_PD0         8'h10
`define DTC_A_GO          8'h20
`define DTC_A_RSP0        8'h24
`define DTC_A_PDRS        8'h34
`endif

/* File: hdl/dtc_pkg.sv */
package dtc_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [3:0][15:0] dtc_words_t;
  typedef logic [1:0][15:0] dtc_pair_t;
  typedef enum logic [2:0] {
    ST_INHIBIT, ST_READY_ON, ST_READY, ST_RUN, ST_RAMPDN, ST_FASTSTOP,
    ST_FAULT
  } dtc_state_t;

  // ----------------------------------------
  // number range offsets and page codes
  // ----------------------------------------
  localparam logic [15:0] PN_OFFSET [9] = '{16'h0000, 16'h07D0, 16'h1770,
    16'h1F40, 16'h2710, 16'h4E20, 16'h6D60, 16'h7530, 16'hEA60};
  localparam logic [7:0]  PN_PAGE   [9] = '{8'h00, 8'h80, 8'h90, 8'h20,
    8'hA0, 8'h50, 8'h70, 8'hF0, 8'h74};

  // full number to {page, field}
  function automatic logic [23:0] dtc_encode(input logic [15:0] num);
    logic [23:0] r;
    r = {PN_PAGE[0], num};
    for (int i = 1; i < 9; i++) begin
      if (num >= PN_OFFSET[i]) begin
        r = {PN_PAGE[i], num - PN_OFFSET[i]};
      end
    end
    return r;
  endfunction : dtc_encode

  // {page, field} to {known page, full number}
  function automatic logic [16:0] dtc_decode(input logic [7:0] page,
                                             input logic [10:0] field);
    logic [16:0] r;
    r = '0;
    for (int i = 0; i < 9; i++) begin
      if (page == PN_PAGE[i]) begin
        r = {1'b1, PN_OFFSET[i] + {5'h00, field}};
      end
    end
    return r;
  endfunction : dtc_decode
endpackage : dtc_pkg

/* File: hdl/dtc_if.sv */
`timescale 1ns/1ps
interface dtc_if import dtc_pkg::*; ();
  logic       reqValid;
  logic       reqReady;
  dtc_words_t parWord;
  dtc_words_t pdWord;
  logic       rspValid;
  dtc_words_t parRsp;
  dtc_pair_t  pdRsp;

  modport dev (input reqValid, parWord, pdWord,
               output reqReady, rspValid, parRsp, pdRsp);
  modport ctl (output reqValid, parWord, pdWord,
               input reqReady, rspValid, parRsp, pdRsp);
endinterface : dtc_if

/* File: hdl/dtc_ramp.sv */
`timescale 1ns/1ps
module dtc_ramp #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // control
  input  wire logic         zero,
  input  wire logic         hold,
  input  wire logic [W-1:0] target,
  input  wire logic [W-1:0] upStep,
  input  wire logic [W-1:0] dnStep,
  // output
  output logic      [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] val;
  } dtc_ramp_st_t;

  dtc_ramp_st_t q, next_q;
  logic signed [W:0] diff;

  always_comb begin
    next_q = q;
    diff   = $signed({target[W-1], target}) - $signed({q.val[W-1], q.val});
    if (zero) begin
      next_q.val = '0;
    end else if (!hold) begin
      // step toward target, magnitude up or down by direction
      if (diff > $signed({1'b0, upStep}) &&
          !q.val[W-1] && !target[W-1]) begin
        next_q.val = q.val + upStep;
      end else if (diff < -$signed({1'b0, dnStep}) &&
                   !q.val[W-1]) begin
        next_q.val = q.val - dnStep;
      end else if (diff < -$signed({1'b0, upStep})) begin
        next_q.val = q.val - upStep;
      end else if (diff > $signed({1'b0, dnStep})) begin
        next_q.val = q.val + dnStep;
      end else begin
        next_q.val = target;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign value = q.val;
endmodule : dtc_ramp

/* File: hdl/dtc_master.sv */
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_master import dtc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // telegram link
  dtc_if.ctl               bus
);
  typedef struct packed {
    logic [15:0] pnum;
    logic [3:0]  code;
    logic [7:0]  sub;
    logic [15:0] valH;
    logic [15:0] valL;
    dtc_words_t  pd;
    logic        busy;
    logic        done;
    logic        reqValid;
    dtc_words_t  rsp;
    dtc_pair_t   pdRsp;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } dtc_mst_st_t;

  dtc_mst_st_t q, next_q;
  logic [23:0] enc;
  logic        wr;
  logic        mapped;

  always_comb begin
    next_q       = q;
    next_q.ready = psel && !penable;
    enc          = dtc_encode(q.pnum);                           // [RULE22]
    wr           = psel && penable && q.ready && pwrite;
    mapped       = paddr[1:0] == 2'h0 && paddr <= `DTC_A_PDRS;
    // ----------------------------------------
    // register access
    // ----------------------------------------
    if (psel && !penable) begin
      next_q.err   = !mapped;
      next_q.rdata = '0;
      case (paddr)
        `DTC_A_PNUM: next_q.rdata = {16'h0000, q.pnum};
        `DTC_A_CODE: next_q.rdata = {16'h0000, q.sub, 4'h0, q.code};
        `DTC_A_VALH: next_q.rdata = {16'h0000, q.valH};
        `DTC_A_VALL: next_q.rdata = {16'h0000, q.valL};
        `DTC_A_GO:   next_q.rdata = {30'h00000000, q.done, q.busy};
        `DTC_A_PDRS: next_q.rdata = {q.pdRsp[1], q.pdRsp[0]};
        default: begin
          if (paddr >= `DTC_A_PD0 && paddr < `DTC_A_GO) begin
            next_q.rdata = {16'h0000, q.pd[paddr[3:2]]};
          end else if (paddr >= `DTC_A_RSP0 && mapped) begin
            next_q.rdata = {16'h0000, q.rsp[2'(paddr[5:2] - 4'h9)]};
          end
        end
      endcase
    end
    if (wr && mapped) begin
      case (paddr)
        `DTC_A_PNUM: next_q.pnum = pwdata[15:0];
        `DTC_A_CODE: begin
          next_q.code = pwdata[3:0];
          next_q.sub  = pwdata[15:8];
        end
        `DTC_A_VALH: next_q.valH = pwdata[15:0];
        `DTC_A_VALL: next_q.valL = pwdata[15:0];
        `DTC_A_GO: begin
          if (!q.busy) begin
            next_q.busy     = 1'b1;
            next_q.done     = 1'b0;
            next_q.reqValid = 1'b1;
          end
        end
        default: begin
          if (paddr >= `DTC_A_PD0 && paddr < `DTC_A_GO) begin
            next_q.pd[paddr[3:2]] = pwdata[15:0] & ((paddr == `DTC_A_PD0)
                                    ? `DTC_CW_USED_MASK : 16'hFFFF); // [RULE23]
          end
        end
      endcase
    end
    // ----------------------------------------
    // telegram handshake
    // ----------------------------------------
    if (q.reqValid && bus.reqReady) begin
      next_q.reqValid = 1'b0;
    end
    if (q.busy && bus.rspValid) begin
      next_q.busy  = 1'b0;
      next_q.done  = 1'b1;
      next_q.rsp   = bus.parRsp;
      next_q.pdRsp = bus.pdRsp;                                  // [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign prdata          = q.rdata;
  assign pready          = q.ready;
  assign pslverr         = q.err;
  assign bus.reqValid    = q.reqValid;
  assign bus.parWord[0]  = {q.code, 1'b0, enc[10:0]};  // [RULE1] [RULE2]
  assign bus.parWord[1]  = {enc[23:16], q.sub};        // [RULE3] [RULE4]
  assign bus.parWord[2]  = q.valH;                               // [RULE5]
  assign bus.parWord[3]  = q.valL;                     // [RULE6] [RULE7]
  assign bus.pdWord      = q.pd;                                 // [RULE8]
endmodule : dtc_master

/* File: dv/dtc_monitor.sv */
`timescale 1ns/1ps
module dtc_monitor import dtc_pkg::*; (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // telegram link
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire dtc_words_t parWord,
  input wire dtc_words_t pdWord,
  input wire logic       rspValid,
  input wire dtc_words_t parRsp,
  input wire dtc_pair_t  pdRsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic       take;
  logic [3:0] code;
  assign take = reqValid && reqReady;
  assign code = parWord[0][15:12];
  // ----------------------------------------
  // link handshake and reply codes
  // ----------------------------------------
  property p_answer; take |=> rspValid; endproperty
  a_answer: assert property (p_answer)
    else $error("reply missing after telegram");
  property p_pulse; rspValid |=> !rspValid; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reply strobe longer than one cycle");
  property p_ready; reqReady |=> reqReady; endproperty
  a_ready: assert property (p_ready)
    else $error("ready dropped");
  property p_ack;
    take && code == 4'h7 && parWord[0][10:0] == 11'h460 &&
      parWord[1] == 16'h0000 |=> parRsp[0][15:12] == 4'h1;
  endproperty
  a_ack: assert property (p_ack)
    else $error("valid write not acknowledged");
  property p_dobj;
    take && code == 4'h7 && parWord[0][10:0] == 11'h348 &&
      parWord[3][15:10] != 6'h3F |=> parRsp[0][15:12] == 4'h8;
  endproperty
  a_dobj: assert property (p_dobj)
    else $error("bad drive object accepted");
  property p_badcode;
    take && !(code inside {4'h0, 4'h6, 4'h7}) |=> parRsp[0][15:12] == 4'h8;
  endproperty
  a_badcode: assert property (p_badcode)
    else $error("unknown request code accepted");
  property p_echo; take |=> parRsp[1] == $past(parWord[1]); endproperty
  a_echo: assert property (p_echo)
    else $error("index word not echoed");
  property p_hold;
    !rspValid |-> $stable(parRsp) && $stable(pdRsp);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply words changed between telegrams");
endmodule : dtc_monitor

/* File: dv/drive_telegram_control_decoder_test.sv */
`timescale 1ns/1ps
module drive_telegram_control_decoder_test import dtc_pkg::*;;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, faultIn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pd;
  logic        pulseEnable, lastErr;
  logic [15:0] speedOut, secondCtl, mopValue;
  logic [15:0] rsp [4];
  int          errTotal, totalChecks;
  dtc_if lnk ();
  dtc_master dtc_master_i (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lnk));
  dtc_device dtc_device_i (.clk(clk), .rstn(rstn), .bus(lnk),
    .faultIn(faultIn), .pulseEnable(pulseEnable), .speedOut(speedOut),
    .secondCtl(secondCtl), .mopValue(mopValue));
  dtc_monitor dtc_monitor_i (.clk(clk), .rstn(rstn),
    .reqValid(lnk.reqValid), .reqReady(lnk.reqReady),
    .parWord(lnk.parWord), .pdWord(lnk.pdWord), .rspValid(lnk.rspValid),
    .parRsp(lnk.parRsp), .pdRsp(lnk.pdRsp));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] g, e);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready === 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic tel(input logic [15:0] num, input logic [3:0] code,
                     input logic [7:0] sub, input logic [15:0] vh, vl,
                     input logic [15:0] cw, sp, c2);
    logic [31:0] r;
    int          n;
    apb(1'b1, 8'h00, {16'h0000, num}, r);
    apb(1'b1, 8'h04, {16'h0000, sub, 4'h0, code}, r);
    apb(1'b1, 8'h08, {16'h0000, vh}, r);
    apb(1'b1, 8'h0C, {16'h0000, vl}, r);
    apb(1'b1, 8'h10, {16'h0000, cw}, r);
    apb(1'b1, 8'h14, {16'h0000, sp}, r);
    apb(1'b1, 8'h18, {16'h0000, c2}, r);
    apb(1'b1, 8'h20, 32'h00000001, r);
    n = 0;
    r = 32'h00000001;
    while (r[0] !== 1'b0 && n < 40) begin
      apb(1'b0, 8'h20, 32'h00000000, r);
      n++;
    end
    chk("status", r[1:0], 2'h2);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'h24 + 8'(4 * i), 32'h00000000, r);
      rsp[i] = r[15:0];
    end
    apb(1'b0, 8'h34, 32'h00000000, pd);
  endtask : tel
  task automatic pdo(input logic [15:0] cw, sp, c2);
    tel(16'h0000, 4'h0, 8'h00, 16'h0000, 16'h0000, cw, sp, c2);
  endtask : pdo
  task automatic wt(input logic [15:0] t);
    int n;
    n = 0;
    while (speedOut !== t && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("speed", speedOut, t);
  endtask : wt
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tSecond;
    pdo(16'h0406, 16'h0000, 16'h1234);
    chk("second ignored", secondCtl, 16'h0000);
    tel(16'h07E6, 4'h7, 8'h00, 16'h0000, 16'h0004, 16'h0006, 0, 0);
    chk("len ack", rsp[0][15:12], 4'h1);
    chk("len page", rsp[1][15:8], 8'h80);
    chk("len field", rsp[0][10:0], 11'h016);
    pdo(16'h0406, 16'h0000, 16'h1234);
    chk("second taken", secondCtl, 16'h1234);
    pdo(16'h0006, 16'h0000, 16'h5678);
    chk("no plc", secondCtl, 16'h1234);
  endtask : tSecond
  task automatic tParams;
    logic [31:0] r;
    tel(16'h0460, 4'h7, 8'h00, 16'h0000, 16'h0020, 16'h0006, 0, 0);
    chk("wr ack", rsp[0][15:12], 4'h1);
    tel(16'h0460, 4'h6, 8'h00, 16'h0000, 16'h0000, 16'h0006, 0, 0);
    chk("rd val", rsp[3], 16'h0020);
    tel(16'h0348, 4'h7, 8'h01, 16'h02D2, 16'hFC02, 16'h0006, 0, 0);
    chk("conn ack", rsp[0][15:12], 4'h1);
    tel(16'h0348, 4'h6, 8'h01, 16'h0000, 16'h0000, 16'h0006, 0, 0);
    chk("conn sub", rsp[1], 16'h0001);
    chk("conn src", rsp[2], 16'h02D2);
    chk("conn low", rsp[3], 16'hFC02);
    tel(16'h0348, 4'h7, 8'h01, 16'h02D2, 16'h0002, 16'h0006, 0, 0);
    chk("bad obj", rsp[0][15:12], 4'h8);
    tel(16'h0460, 4'h3, 8'h00, 16'h0000, 16'h0000, 16'h0006, 0, 0);
    chk("bad code", rsp[0][15:12], 4'h8);
    apb(1'b0, 8'h40, 32'h00000000, r);
    chk("unmapped", lastErr, 1'b1);
  endtask : tParams
  task automatic tDrive;
    pdo(16'h0406, 16'h0000, 16'h0000);
    pdo(16'h047F, 16'h0100, 16'h0000);
    chk("run", pulseEnable, 1'b1);
    wt(16'h0100);
    pdo(16'h977F, 16'h0100, 16'h0000);
    chk("reserved", pulseEnable, 1'b1);
    pdo(16'h045F, 16'h0000, 16'h0000);
    repeat (20) @(posedge clk);
    chk("freeze", speedOut, 16'h0100);
    pdo(16'h0C7F, 16'h0100, 16'h0000);
    wt(16'hFF00);
    pdo(16'h046F, 16'h0100, 16'h0000);
    chk("rfg zero", speedOut, 16'h0000);
    pdo(16'h047D, 16'h0100, 16'h0000);
    chk("coast", pulseEnable, 1'b0);
    pdo(16'h0406, 16'h0000, 16'h0000);
    pdo(16'h047F, 16'h0000, 16'h0000);
    pdo(16'h0477, 16'h0000, 16'h0000);
    chk("inhibit op", pulseEnable, 1'b0);
    pdo(16'h2406, 16'h0000, 16'h0000);
    pdo(16'h2406, 16'h0000, 16'h0000);
    chk("mop up", mopValue, 16'h0002);
    pdo(16'h4406, 16'h0000, 16'h0000);
    chk("mop down", mopValue, 16'h0001);
  endtask : tDrive
  task automatic tStop;
    pdo(16'h047F, 16'h0800, 16'h0000);
    wt(16'h0801);
    pdo(16'h047E, 16'h0800, 16'h0000);
    chk("pd run", pd, 32'h08014036);
    chk("ramping", pulseEnable, 1'b1);
    wt(16'h0000);
    repeat (2) @(posedge clk);
    chk("ramp_stop_command", pulseEnable, 1'b0);
    pdo(16'h047F, 16'h0800, 16'h0000);
    wt(16'h0801);
    pdo(16'h047B, 16'h0800, 16'h0000);
    repeat (20) @(posedge clk);
    chk("fast", speedOut, 16'h0000);
    chk("fast_stop_command", pulseEnable, 1'b0);
  endtask : tStop
  task automatic tFault;
    faultIn <= 1'b1;
    @(posedge clk);
    faultIn <= 1'b0;
    pdo(16'h0406, 16'h0000, 16'h0000);
    chk("fault", pd, 32'h00000018);
    pdo(16'h0487, 16'h0000, 16'h0000);
    pdo(16'h0407, 16'h0000, 16'h0000);
    chk("acked", pd, 32'h00000070);
  endtask : tFault
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : printVerdict
  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, psel, penable, pwrite, faultIn} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    errTotal = 0;
    totalChecks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    tSecond();
    tParams();
    tDrive();
    tStop();
    tFault();
    printVerdict();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errTotal++;
    printVerdict();
  end
endmodule : drive_telegram_control_decoder_test
